// file: rtl/ocp_defines.svh
// register map, field layout, reset values and timing counts of the overcurrent block
`ifndef OCP_DEFINES_SVH
`define OCP_DEFINES_SVH

// register byte addresses
`define OCP_ADDR_INST_CTRL     8'h00
`define OCP_ADDR_INST_START    8'h04
`define OCP_ADDR_TIMED_CTRL    8'h08
`define OCP_ADDR_TIMED_START   8'h0c
`define OCP_ADDR_TIMED_TMS     8'h10
`define OCP_ADDR_MIN_DELAY     8'h14
`define OCP_ADDR_DEF_DELAY     8'h18
`define OCP_ADDR_RESET_DELAY   8'h1c
`define OCP_ADDR_STATUS        8'h20

// reset values
`define OCP_INST_START_RST     32'h0000_00c8
`define OCP_TIMED_START_RST    32'h0000_00c8
`define OCP_TMS_RST            32'h0000_0064
`define OCP_DELAY_RST          32'h0000_0064

// setting ranges
`define OCP_INST_START_MIN     32'h0000_0014
`define OCP_INST_START_MAX     32'h0000_0bb8
`define OCP_TIMED_START_MIN    32'h0000_0014
`define OCP_TIMED_START_MAX    32'h0000_03e8
`define OCP_TMS_MIN            32'h0000_0005
`define OCP_TMS_MAX            32'h0001_869c
`define OCP_DELAY_MAX          32'h0000_ea60

// status field positions
`define OCP_ST_INST_TRIP       0
`define OCP_ST_INST_GEN        3
`define OCP_ST_TIMED_START     4
`define OCP_ST_TIMED_GEN_START 7
`define OCP_ST_TIMED_GEN_TRIP  8

// fixed point
`define OCP_FULL               64'h0000_0000_0100_0000
`define OCP_ONE_Q16            64'h0000_0000_0001_0000
`define OCP_RATIO_LIMIT        64'h0000_0000_0014_0000
`define OCP_ALPHA_SMALL_LN2    64'h0000_0000_0000_038c
`define OCP_TENTHS_PER_MS      64'h0000_0000_0000_000a
`define OCP_HUNDRED            64'h0000_0000_0000_0064

// timing: one progress step per millisecond
`define OCP_TICK_US            1000
`define OCP_CLK_MHZ            100
`define OCP_TICK_CYCLES        (`OCP_TICK_US * `OCP_CLK_MHZ)

`endif

// file: rtl/ocp_pkg.sv
// types shared by the overcurrent block
package ocp_pkg;

    typedef enum logic [1:0] {I_OFF, I_PEAK, I_FUND} inst_op_t;

    typedef enum logic [3:0] {
        T_OFF, T_DEFINITE, T_IEC_INV, T_IEC_VERY, T_IEC_EXT, T_IEC_LONG,
        T_ANSI_INV, T_ANSI_MOD, T_ANSI_VERY, T_ANSI_EXT, T_ANSI_LONG,
        T_ANSI_LONG_VERY, T_ANSI_LONG_EXT
    } timed_op_t;

    typedef enum logic [1:0] {ALPHA_SMALL, ALPHA_ONE, ALPHA_TWO} alpha_t;

    typedef enum logic [1:0] {TS_IDLE, TS_PICKED, TS_DROPPING} timed_state_t;

endpackage

// file: rtl/curve_rom.sv
// curve constant table, times in units of 0.1 ms, registered read
module curve_rom
    import ocp_pkg::*;
(
    // clock
    input  wire logic        i_clk,
    // lookup
    input  wire logic [3:0]  i_curve,
    output logic      [20:0] o_k,
    output logic      [12:0] o_c,
    output logic      [18:0] o_kr,
    output alpha_t           o_alpha
);

    always_ff @(posedge i_clk)
    begin
        case (i_curve)
            4'h0:    begin o_k <= 21'h000578; o_c <= 13'h0000; o_kr <= 19'h00000; o_alpha <= ALPHA_SMALL; end
            4'h1:    begin o_k <= 21'h020f58; o_c <= 13'h0000; o_kr <= 19'h00000; o_alpha <= ALPHA_ONE;   end
            4'h2:    begin o_k <= 21'h0c3500; o_c <= 13'h0000; o_kr <= 19'h00000; o_alpha <= ALPHA_TWO;   end
            4'h3:    begin o_k <= 21'h124f80; o_c <= 13'h0000; o_kr <= 19'h00000; o_alpha <= ALPHA_ONE;   end
            4'h4:    begin o_k <= 21'h000056; o_c <= 13'h00b9; o_kr <= 19'h011f8; o_alpha <= ALPHA_SMALL; end
            4'h5:    begin o_k <= 21'h000203; o_c <= 13'h0474; o_kr <= 19'h0bd74; o_alpha <= ALPHA_SMALL; end
            4'h6:    begin o_k <= 21'h02fe04; o_c <= 13'h132e; o_kr <= 19'h34bc0; o_alpha <= ALPHA_TWO;   end
            4'h7:    begin o_k <= 21'h044d90; o_c <= 13'h04c1; o_kr <= 19'h470b8; o_alpha <= ALPHA_TWO;   end
            4'h8:    begin o_k <= 21'h00035c; o_c <= 13'h073a; o_kr <= 19'h0b3b0; o_alpha <= ALPHA_SMALL; end
            4'h9:    begin o_k <= 21'h045b3c; o_c <= 13'h1bd0; o_kr <= 19'h20dc8; o_alpha <= ALPHA_TWO;   end
            4'ha:    begin o_k <= 21'h09c6bc; o_c <= 13'h09c4; o_kr <= 19'h493e0; o_alpha <= ALPHA_TWO;   end
            default: begin o_k <= 21'h000578; o_c <= 13'h0000; o_kr <= 19'h00000; o_alpha <= ALPHA_SMALL; end
        endcase
    end

endmodule

// file: rtl/overcurrent_protection_logic.sv
// instantaneous and timed phase overcurrent elements with apb settings
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "ocp_defines.svh"

module overcurrent_protection_logic
    import ocp_pkg::*;
#(
    parameter int TICK_CYCLES = `OCP_TICK_CYCLES
)
(
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_NRST,
    // apb slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // phase currents, percent of rated
    input  wire logic [15:0] I_PHASE1_PEAK_CURRENT,
    input  wire logic [15:0] I_PHASE2_PEAK_CURRENT,
    input  wire logic [15:0] I_PHASE3_PEAK_CURRENT,
    input  wire logic [15:0] I_PHASE1_FUNDAMENTAL_CURRENT,
    input  wire logic [15:0] I_PHASE2_FUNDAMENTAL_CURRENT,
    input  wire logic [15:0] I_PHASE3_FUNDAMENTAL_CURRENT,
    // binary inputs
    input  wire logic        I_INSTANT_DOUBLE,
    input  wire logic        I_INSTANT_DISABLE,
    input  wire logic        I_TIMED_DISABLE,
    // element outputs
    output logic      [2:0]  O_INSTANT_TRIP,
    output logic             O_INSTANT_TRIP_GENERAL,
    output logic      [2:0]  O_TIMED_START,
    output logic             O_TIMED_START_GENERAL,
    output logic             O_TIMED_TRIP_GENERAL
);

    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [63:0] div(input logic [63:0] num, input logic [63:0] den);
        div = num / ((den == 64'h0) ? 64'h1 : den);
    endfunction

    // log2 of a q16 value >= 1.0, q16 result with linear fraction
    function automatic logic [63:0] log2_q16(input logic [31:0] v);
        logic [4:0]  msb;
        logic [31:0] norm;
        msb = 5'h10;
        for (int i = 16; i < 32; i++)
        begin
            if (v[i])
            begin
                msb = 5'(i);
            end
        end
        norm = v << (5'h1f - msb);
        log2_q16 = {43'h0, 5'(msb - 5'h10), norm[30:15]};
    endfunction

    // settings
    inst_op_t    inst_op;
    timed_op_t   timed_op;
    logic [11:0] inst_start;
    logic [9:0]  timed_start;
    logic [16:0] tms;
    logic [15:0] min_delay;
    logic [15:0] def_delay;
    logic [15:0] reset_delay;

    // synchronised binary inputs
    logic [2:0] bin_meta;
    logic [2:0] bin_sync;
    logic       dbl;
    logic       inst_dis;
    logic       timed_dis;

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            bin_meta <= 3'h0;
            bin_sync <= 3'h0;
        end
        else
        begin
            bin_meta <= {I_TIMED_DISABLE, I_INSTANT_DISABLE, I_INSTANT_DOUBLE};
            bin_sync <= bin_meta;
        end
    end

    assign dbl       = bin_sync[0];
    assign inst_dis  = bin_sync[1];
    assign timed_dis = bin_sync[2];

    // apb access
    logic apb_wr;
    logic apb_rd;
    logic mapped;
    logic [31:0] next_prdata;

    assign apb_wr    = I_PSEL && I_PENABLE && I_PWRITE;
    assign apb_rd    = I_PSEL && I_PENABLE && !I_PWRITE;
    assign mapped    = (I_PADDR <= `OCP_ADDR_STATUS) && (I_PADDR[1:0] == 2'h0);
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            inst_op     <= I_PEAK;
            inst_start  <= 12'(`OCP_INST_START_RST);
            timed_op    <= T_DEFINITE;
            timed_start <= 10'(`OCP_TIMED_START_RST);
            tms         <= 17'(`OCP_TMS_RST);
            min_delay   <= 16'(`OCP_DELAY_RST);
            def_delay   <= 16'(`OCP_DELAY_RST);
            reset_delay <= 16'(`OCP_DELAY_RST);
        end
        else if (apb_wr)
        begin
            case (I_PADDR)
                `OCP_ADDR_INST_CTRL:
                    inst_op <= (I_PWDATA[1:0] == 2'h3) ? I_OFF : inst_op_t'(I_PWDATA[1:0]);
                `OCP_ADDR_INST_START:
                    inst_start <= 12'(clamp(I_PWDATA, `OCP_INST_START_MIN,
                                            `OCP_INST_START_MAX));
                `OCP_ADDR_TIMED_CTRL:
                    timed_op <= (I_PWDATA[3:0] > 4'hc) ? T_OFF : timed_op_t'(I_PWDATA[3:0]);
                `OCP_ADDR_TIMED_START:
                    timed_start <= 10'(clamp(I_PWDATA, `OCP_TIMED_START_MIN,
                                             `OCP_TIMED_START_MAX));
                `OCP_ADDR_TIMED_TMS:
                    tms <= 17'(clamp(I_PWDATA, `OCP_TMS_MIN, `OCP_TMS_MAX));
                `OCP_ADDR_MIN_DELAY:
                    min_delay <= 16'(clamp(I_PWDATA, 32'h0, `OCP_DELAY_MAX));
                `OCP_ADDR_DEF_DELAY:
                    def_delay <= 16'(clamp(I_PWDATA, 32'h0, `OCP_DELAY_MAX));
                `OCP_ADDR_RESET_DELAY:
                    reset_delay <= 16'(clamp(I_PWDATA, 32'h0, `OCP_DELAY_MAX));
                default:
                    inst_op <= inst_op;
            endcase
        end
    end

    always_comb
    begin
        next_prdata = 32'h0;
        case (I_PADDR)
            `OCP_ADDR_INST_CTRL:   next_prdata = {30'h0, inst_op};
            `OCP_ADDR_INST_START:  next_prdata = {20'h0, inst_start};
            `OCP_ADDR_TIMED_CTRL:  next_prdata = {28'h0, timed_op};
            `OCP_ADDR_TIMED_START: next_prdata = {22'h0, timed_start};
            `OCP_ADDR_TIMED_TMS:   next_prdata = {15'h0, tms};
            `OCP_ADDR_MIN_DELAY:   next_prdata = {16'h0, min_delay};
            `OCP_ADDR_DEF_DELAY:   next_prdata = {16'h0, def_delay};
            `OCP_ADDR_RESET_DELAY: next_prdata = {16'h0, reset_delay};
            `OCP_ADDR_STATUS:
            begin
                next_prdata[`OCP_ST_INST_TRIP +: 3]      = O_INSTANT_TRIP;
                next_prdata[`OCP_ST_INST_GEN]            = O_INSTANT_TRIP_GENERAL;
                next_prdata[`OCP_ST_TIMED_START +: 3]    = O_TIMED_START;
                next_prdata[`OCP_ST_TIMED_GEN_START]     = O_TIMED_START_GENERAL;
                next_prdata[`OCP_ST_TIMED_GEN_TRIP]      = O_TIMED_TRIP_GENERAL;
            end
            default:               next_prdata = 32'h0;
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            O_PRDATA <= 32'h0;
        end
        else if (I_PSEL && !I_PENABLE && !I_PWRITE)
        begin
            O_PRDATA <= next_prdata;
        end
    end

    // instantaneous element
    logic [15:0] peak [3];
    logic [15:0] fund [3];
    logic [12:0] inst_thr;
    logic [2:0]  next_inst_trip;

    assign peak = '{I_PHASE1_PEAK_CURRENT, I_PHASE2_PEAK_CURRENT, I_PHASE3_PEAK_CURRENT};
    assign fund = '{I_PHASE1_FUNDAMENTAL_CURRENT, I_PHASE2_FUNDAMENTAL_CURRENT,
                    I_PHASE3_FUNDAMENTAL_CURRENT};
    assign inst_thr = dbl ? {inst_start, 1'b0} : {1'b0, inst_start};

    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            next_inst_trip[p] = ((inst_op == I_PEAK) ? peak[p] : fund[p]) > {3'h0, inst_thr};
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST || inst_op == I_OFF || inst_dis)
        begin
            O_INSTANT_TRIP         <= 3'h0;
            O_INSTANT_TRIP_GENERAL <= 1'b0;
        end
        else
        begin
            O_INSTANT_TRIP         <= next_inst_trip;
            O_INSTANT_TRIP_GENERAL <= |next_inst_trip;
        end
    end

    // timed element: curve constants
    logic [20:0] k01;
    logic [12:0] c01;
    logic [18:0] kr01;
    alpha_t      alpha;
    logic        is_ansi;

    curve_rom u_curve_rom (
        .i_clk   (I_CLK),
        .i_curve (4'(timed_op - T_IEC_INV)),
        .o_k     (k01),
        .o_c     (c01),
        .o_kr    (kr01),
        .o_alpha (alpha)
    );

    assign is_ansi = timed_op >= T_ANSI_INV;

    // timed element: curve arithmetic
    logic [15:0] gmax;
    logic [2:0]  phase_start;
    logic        pickup;
    logic [63:0] ratio;
    logic [63:0] ratio2;
    logic [63:0] denom;
    logic [63:0] t_op;
    logic [63:0] t_rst;
    logic [63:0] inc;
    logic [63:0] dec;

    always_comb
    begin
        gmax = 16'h0;
        for (int p = 0; p < 3; p++)
        begin
            phase_start[p] = fund[p] > {6'h0, timed_start};
            gmax = (fund[p] > gmax) ? fund[p] : gmax;
        end
        pickup = |phase_start;
        ratio  = div({32'h0, gmax, 16'h0}, {54'h0, timed_start});
        ratio  = (ratio > `OCP_RATIO_LIMIT) ? `OCP_RATIO_LIMIT : ratio;
        ratio2 = (ratio * ratio) >> 16;
        case (alpha)
            ALPHA_ONE: denom = ratio - `OCP_ONE_Q16;
            ALPHA_TWO: denom = ratio2 - `OCP_ONE_Q16;
            default:   denom = (log2_q16(ratio[31:0]) * `OCP_ALPHA_SMALL_LN2) >> 16;
        endcase
        denom = pickup ? denom : `OCP_ONE_Q16;
        t_op  = div(({43'h0, k01} << 16), denom) + {51'h0, c01};
        t_op  = div(t_op * {47'h0, tms}, `OCP_HUNDRED);
        if ({48'h0, min_delay} * `OCP_TENTHS_PER_MS > t_op)
        begin
            t_op = {48'h0, min_delay} * `OCP_TENTHS_PER_MS;
        end
        t_rst = div((({45'h0, kr01} * {47'h0, tms}) << 16),
                    (pickup ? `OCP_ONE_Q16 : `OCP_ONE_Q16 - ratio2) * `OCP_HUNDRED);
        inc = div(`OCP_FULL * `OCP_TENTHS_PER_MS, t_op);
        dec = div(`OCP_FULL * `OCP_TENTHS_PER_MS, t_rst);
    end

    // millisecond step enable
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
    logic                           tick;

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST || tick)
        begin
            tick_cnt <= '0;
        end
        else
        begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    assign tick = tick_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

    // timed element: progress and reset timing
    timed_state_t tstate;
    logic [24:0]  acc;
    logic [15:0]  rst_cnt;
    logic         timed_clear;
    logic         full;

    assign timed_clear = !I_NRST || timed_op == T_OFF || timed_dis;
    assign full = (timed_op == T_DEFINITE) ? ({9'h0, def_delay} <= acc)
                                           : (acc == 25'(`OCP_FULL));

    always_ff @(posedge I_CLK)
    begin
        if (timed_clear)
        begin
            tstate  <= TS_IDLE;
            acc     <= 25'h0;
            rst_cnt <= 16'h0;
        end
        else if (tick)
        begin
            case (tstate)
                TS_IDLE:
                begin
                    if (pickup)
                    begin
                        tstate <= TS_PICKED;
                    end
                end
                TS_PICKED:
                begin
                    if (!pickup && timed_op == T_DEFINITE)
                    begin
                        tstate <= TS_IDLE;
                        acc    <= 25'h0;
                    end
                    else if (!pickup)
                    begin
                        tstate  <= TS_DROPPING;
                        rst_cnt <= 16'h0;
                    end
                    else if (timed_op == T_DEFINITE)
                    begin
                        acc <= full ? acc : acc + 25'h1;
                    end
                    else
                    begin
                        acc <= (({39'h0, acc} + inc) >= `OCP_FULL) ? 25'(`OCP_FULL)
                               : 25'({39'h0, acc} + inc);
                    end
                end
                TS_DROPPING:
                begin
                    if (pickup)
                    begin
                        tstate <= TS_PICKED;
                    end
                    else if (!is_ansi && rst_cnt + 16'h1 >= reset_delay)
                    begin
                        tstate <= TS_IDLE;
                        acc    <= 25'h0;
                    end
                    else if (!is_ansi)
                    begin
                        rst_cnt <= rst_cnt + 16'h1;
                    end
                    else if ({39'h0, acc} <= dec)
                    begin
                        tstate <= TS_IDLE;
                        acc    <= 25'h0;
                    end
                    else
                    begin
                        acc <= 25'({39'h0, acc} - dec);
                    end
                end
                default:
                begin
                    tstate <= TS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (timed_clear)
        begin
            O_TIMED_START         <= 3'h0;
            O_TIMED_START_GENERAL <= 1'b0;
            O_TIMED_TRIP_GENERAL  <= 1'b0;
        end
        else
        begin
            O_TIMED_START         <= phase_start;
            O_TIMED_START_GENERAL <= pickup;
            O_TIMED_TRIP_GENERAL  <= pickup && tstate == TS_PICKED && full;
        end
    end

endmodule

// file: sim/ocp_chk.sv
// port assertions of the overcurrent block
module ocp_chk
#(
    parameter int TICK_CYCLES = 10
)
(
    // clock and reset
    input wire logic        I_CLK,
    input wire logic        I_NRST,
    // apb
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    // currents
    input wire logic [15:0] I_PHASE1_PEAK_CURRENT,
    input wire logic [15:0] I_PHASE2_PEAK_CURRENT,
    input wire logic [15:0] I_PHASE3_PEAK_CURRENT,
    input wire logic [15:0] I_PHASE1_FUNDAMENTAL_CURRENT,
    input wire logic [15:0] I_PHASE2_FUNDAMENTAL_CURRENT,
    input wire logic [15:0] I_PHASE3_FUNDAMENTAL_CURRENT,
    // binary inputs
    input wire logic        I_INSTANT_DOUBLE,
    input wire logic        I_INSTANT_DISABLE,
    input wire logic        I_TIMED_DISABLE,
    // element outputs
    input wire logic [2:0]  O_INSTANT_TRIP,
    input wire logic        O_INSTANT_TRIP_GENERAL,
    input wire logic [2:0]  O_TIMED_START,
    input wire logic        O_TIMED_START_GENERAL,
    input wire logic        O_TIMED_TRIP_GENERAL
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);

    chk_inst_general: assert property (O_INSTANT_TRIP_GENERAL == |O_INSTANT_TRIP)
        else $error("instant general trip differs from phase trips");
    chk_timed_general: assert property (O_TIMED_START_GENERAL == |O_TIMED_START)
        else $error("timed general start differs from phase starts");
    chk_trip_has_start: assert property (O_TIMED_TRIP_GENERAL |-> O_TIMED_START_GENERAL)
        else $error("timed trip without start");
    chk_trip_after_start: assert property ($rose(O_TIMED_TRIP_GENERAL) |-> $past(O_TIMED_START_GENERAL))
        else $error("timed trip rose without earlier start");
    chk_inst_below_min: assert property (I_PHASE1_PEAK_CURRENT <= 16'h0014
        && I_PHASE1_FUNDAMENTAL_CURRENT <= 16'h0014 |=> !O_INSTANT_TRIP[0])
        else $error("instant trip below smallest start current");
    chk_timed_below_min: assert property (I_PHASE1_FUNDAMENTAL_CURRENT <= 16'h0014
        |=> !O_TIMED_START[0])
        else $error("timed start below smallest start current");
    chk_inst_disabled: assert property (I_INSTANT_DISABLE [*5] |-> O_INSTANT_TRIP == 3'h0)
        else $error("instant trip while disabled");
    chk_timed_disabled: assert property (I_TIMED_DISABLE [*5]
        |-> !O_TIMED_START_GENERAL && !O_TIMED_TRIP_GENERAL)
        else $error("timed output while disabled");

    cover property (O_INSTANT_TRIP_GENERAL);
    cover property (O_TIMED_TRIP_GENERAL);
    cover property (I_PSEL && I_PENABLE && O_PSLVERR);
endmodule

bind overcurrent_protection_logic ocp_chk #(.TICK_CYCLES(TICK_CYCLES)) u_ocp_chk (.*);

// file: sim/current_source_model.sv
// upstream measurement model giving peak and fundamental magnitudes
module current_source_model (
    // measured magnitudes
    output logic [15:0] o_peak1,
    output logic [15:0] o_peak2,
    output logic [15:0] o_peak3,
    output logic [15:0] o_fund1,
    output logic [15:0] o_fund2,
    output logic [15:0] o_fund3
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pk [3] = '{default: 16'h0000};
    logic [15:0] fd [3] = '{default: 16'h0000};

    // one phase updated per call, just after a clock edge
    task automatic drive(input int ph, input logic [15:0] p, input logic [15:0] f);
        pk[ph-1] <= p;
        fd[ph-1] <= f;
    endtask

    assign o_peak1 = pk[0];
    assign o_peak2 = pk[1];
    assign o_peak3 = pk[2];
    assign o_fund1 = fd[0];
    assign o_fund2 = fd[1];
    assign o_fund3 = fd[2];
endmodule

// file: sim/overcurrent_protection_logic_tb.sv
// self-checking bench of the overcurrent block
module overcurrent_protection_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    localparam logic [31:0] RST [9] = '{32'h1, 32'hc8, 32'h1, 32'hc8, 32'h64,
                                        32'h64, 32'h64, 32'h64, 32'h0};
    logic        I_CLK = 1'b0;
    logic        I_NRST = 1'b0;
    logic        I_PSEL = 1'b0;
    logic        I_PENABLE = 1'b0;
    logic        I_PWRITE = 1'b0;
    logic [7:0]  I_PADDR = 8'h00;
    logic [31:0] I_PWDATA = 32'h0;
    logic        I_INSTANT_DOUBLE = 1'b0;
    logic        I_INSTANT_DISABLE = 1'b0;
    logic        I_TIMED_DISABLE = 1'b0;
    logic [15:0] pk1, pk2, pk3, fd1, fd2, fd3;
    logic [31:0] O_PRDATA;
    logic        O_PREADY, O_PSLVERR, O_INSTANT_TRIP_GENERAL;
    logic        O_TIMED_START_GENERAL, O_TIMED_TRIP_GENERAL;
    logic [2:0]  O_INSTANT_TRIP, O_TIMED_START;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    current_source_model u_current_source_model (.o_peak1(pk1), .o_peak2(pk2),
        .o_peak3(pk3), .o_fund1(fd1), .o_fund2(fd2), .o_fund3(fd3));

    overcurrent_protection_logic #(.TICK_CYCLES(TICK)) u_overcurrent_protection_logic (
        .I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
        .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
        .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
        .I_PHASE1_PEAK_CURRENT(pk1), .I_PHASE2_PEAK_CURRENT(pk2),
        .I_PHASE3_PEAK_CURRENT(pk3), .I_PHASE1_FUNDAMENTAL_CURRENT(fd1),
        .I_PHASE2_FUNDAMENTAL_CURRENT(fd2), .I_PHASE3_FUNDAMENTAL_CURRENT(fd3),
        .I_INSTANT_DOUBLE(I_INSTANT_DOUBLE), .I_INSTANT_DISABLE(I_INSTANT_DISABLE),
        .I_TIMED_DISABLE(I_TIMED_DISABLE), .O_INSTANT_TRIP(O_INSTANT_TRIP),
        .O_INSTANT_TRIP_GENERAL(O_INSTANT_TRIP_GENERAL), .O_TIMED_START(O_TIMED_START),
        .O_TIMED_START_GENERAL(O_TIMED_START_GENERAL),
        .O_TIMED_TRIP_GENERAL(O_TIMED_TRIP_GENERAL));

    initial
    begin
        forever #5 I_CLK = ~I_CLK;
    end

    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard
    always @(posedge I_CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // outputs as {trip, gen start, start[2:0], inst gen, inst trip[2:0]}
    task automatic cmp_out(input logic [8:0] exp);
        logic [8:0] got;
        got = {O_TIMED_TRIP_GENERAL, O_TIMED_START_GENERAL, O_TIMED_START,
               O_INSTANT_TRIP_GENERAL, O_INSTANT_TRIP};
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_PSEL    <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE  <= wr;
        I_PADDR   <= a;
        I_PWDATA  <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        @(posedge I_CLK);
        while (O_PREADY !== 1'b1)
            @(posedge I_CLK);
        rd = O_PRDATA;
        err = O_PSLVERR;
        I_PSEL    <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        cmp_reg(rd, exp);
        cmp_reg({31'h0, err}, {31'h0, e});
    endtask

    task automatic settle();
        repeat (6) @(posedge I_CLK);
    endtask

    task automatic ms(input int n);
        repeat (n * TICK) @(posedge I_CLK);
    endtask

    initial
    begin
        repeat (10) @(posedge I_CLK);
        I_NRST <= 1'b1;
        for (int i = 0; i < 9; i++)
            rdc(8'(i * 4), RST[i], 1'b0);
        rdc(8'h24, 32'h0, 1'b1);
        rdc(8'h02, 32'h0, 1'b1);
        wr(8'h04, 32'h0a);
        rdc(8'h04, 32'h14, 1'b0);
        wr(8'h04, 32'hfa0);
        rdc(8'h04, 32'hbb8, 1'b0);
        for (int i = 0; i < 13; i++)
        begin
            wr(8'h08, 32'(i));
            rdc(8'h08, 32'(i), 1'b0);
        end
        wr(8'h04, 32'h12c);
        wr(8'h08, 32'h1);
        wr(8'h18, 32'h5);
        // peak mode, start 300
        u_current_source_model.drive(1, 16'd300, 16'd0);
        settle();
        cmp_out(9'h000);
        u_current_source_model.drive(1, 16'd301, 16'd0);
        settle();
        cmp_out(9'h009);
        rdc(8'h20, 32'h9, 1'b0);
        u_current_source_model.drive(1, 16'd0, 16'd0);
        // fundamental mode ignores peak
        wr(8'h00, 32'h2);
        u_current_source_model.drive(2, 16'd1000, 16'd0);
        settle();
        cmp_out(9'h000);
        u_current_source_model.drive(2, 16'd0, 16'd301);
        settle();
        cmp_out(9'h0aa);
        ms(3);
        cmp_out(9'h0aa);
        ms(4);
        cmp_out(9'h1aa);
        I_INSTANT_DOUBLE <= 1'b1;
        settle();
        cmp_out(9'h1a0);
        u_current_source_model.drive(2, 16'd0, 16'd601);
        settle();
        cmp_out(9'h1aa);
        I_INSTANT_DOUBLE <= 1'b0;
        I_INSTANT_DISABLE <= 1'b1;
        settle();
        cmp_out(9'h1a0);
        I_TIMED_DISABLE <= 1'b1;
        settle();
        cmp_out(9'h000);
        I_INSTANT_DISABLE <= 1'b0;
        I_TIMED_DISABLE <= 1'b0;
        settle();
        cmp_out(9'h0aa);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h0);
        settle();
        cmp_out(9'h000);
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h1);
        settle();
        cmp_out(9'h0a0);
        // IEC very inverse, TMS 0.05, ratio 40 held at 20
        wr(8'h08, 32'h0);
        wr(8'h08, 32'h3);
        wr(8'h10, 32'h5);
        wr(8'h14, 32'h0);
        u_current_source_model.drive(2, 16'd0, 16'd8000);
        ms(28);
        cmp_out(9'h0a0);
        ms(14);
        cmp_out(9'h1a0);
        wr(8'h08, 32'h0);
        wr(8'h08, 32'h3);
        wr(8'h14, 32'h3c);
        ms(50);
        cmp_out(9'h0a0);
        ms(15);
        cmp_out(9'h1a0);
        // third phase trip and start
        u_current_source_model.drive(3, 16'd301, 16'd301);
        settle();
        cmp_out(9'h1ec);
        // reset delay 5 ms: progress kept, then cleared
        wr(8'h1c, 32'h5);
        u_current_source_model.drive(2, 16'd0, 16'd0);
        u_current_source_model.drive(3, 16'd0, 16'd0);
        ms(2);
        cmp_out(9'h000);
        u_current_source_model.drive(2, 16'd0, 16'd8000);
        ms(2);
        cmp_out(9'h1a0);
        u_current_source_model.drive(2, 16'd0, 16'd0);
        ms(8);
        u_current_source_model.drive(2, 16'd0, 16'd8000);
        ms(2);
        cmp_out(9'h0a0);
        complete_run();
    end
endmodule
